/* rtl/ftg_pkg.sv */
// shared constants for the four-phase timing generator
package ftg_pkg;
   // ------------------------------------------------------------
   // divider counts and reset values
   // ------------------------------------------------------------
   localparam logic [1:0] FTG_CNT_PH1 = 2'h0;
   localparam logic [1:0] FTG_CNT_PH2 = 2'h1;
   localparam logic [1:0] FTG_CNT_PH3 = 2'h2;
   localparam logic [1:0] FTG_CNT_PH4 = 2'h3;
   localparam logic [1:0] FTG_CNT_RST = 2'h0;
   localparam int FTG_CHAIN_STAGES = 4;
   localparam logic [3:0] FTG_CHAIN_RST = 4'h0;
   // ------------------------------------------------------------
   // probe generator states
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      FTG_PRB_IDLE = 2'b00,
      FTG_PRB_HELD = 2'b01,
      FTG_PRB_ARMED = 2'b10
   } ftg_prb_e;
endpackage : ftg_pkg

/* rtl/ftg_timing_gen.sv */
// four-phase timing generator: divider, decoder, countdown, sync and probe logic
// Functional notes
// - the input clock strobe is divided by two and again by two in two stages.
// - the two stages step 00, 01, 10, 11 with one count per input strobe.
// - each strobe is decoded into phase one to four for counts 00 to 11.
// - each phase strobe is one strobe wide and repeats once per four strobes.
// - the phase strobes never coincide and split the cycle in four equal parts.
// - phase four drives a divide-by-sixteen chain giving 6.4k and 800 pps trains.
// - the 800 pps phase-four train goes out to the read counter rate logic.
// - the fast sync carries phase four, or the halved train while coarse align is on.
// - the sync output is phase two OR phase four.
// - after each probe pulse, except one merged into a pair already held or armed, one second probe comes on phase two and one third on phase three.
// - master and slave of a toggle stage are never gated in the same instant.
// - an up-down stage takes direction at phase two and counts at phase four.
// - an up-down stage gives a carry when counting up and a borrow when counting down.
// - a probe sets a holding flop, moved on at phase one, cleared by the second probe.
// - the phase four after the second and third probes clears the second flop.
`timescale 1ns/1ps
module ftg_timing_gen (
   // clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // computer clock strobe and mode inputs
   input wire logic input_clock_strobe,
   input wire logic coarse_align_enable,
   input wire logic probe_pulse,
   // up-down stage inputs
   input wire logic count_up,
   input wire logic count_down,
   input wire logic count_in,
   // phase strobes
   output logic phase1_q,
   output logic phase2_q,
   output logic phase3_q,
   output logic phase4_q,
   // divided trains
   output logic div_a_q,
   output logic div_b_q,
   output logic rate_6k4_q,
   output logic rate_800_q,
   output logic fast_sync_q,
   output logic sync_25k6_q,
   // probe outputs
   output logic second_probe_pulse,
   output logic third_probe_pulse,
   // up-down stage outputs
   output logic ud_bit,
   output logic ud_carry,
   output logic ud_borrow
);
   // ------------------------------------------------------------
   // clock divider and phase decoder
   // ------------------------------------------------------------
   logic [1:0] cnt_q, cnt_d;
   logic [3:0] ph_q, ph_d;

   // one-hot phase strobe for each divider count
   function automatic logic [3:0] ftg_phase_of(input logic [1:0] count);
      logic [3:0] onehot;
      case (count)
         ftg_pkg::FTG_CNT_PH1: onehot = 4'h1;
         ftg_pkg::FTG_CNT_PH2: onehot = 4'h2;
         ftg_pkg::FTG_CNT_PH3: onehot = 4'h4;
         ftg_pkg::FTG_CNT_PH4: onehot = 4'h8;
         default: onehot = 4'h0;
      endcase
      return onehot;
   endfunction : ftg_phase_of

   // one count per strobe; the decode uses the count held before the step
   // the strobe is taken as one cycle wide: a wider one would step the count
   // on every cycle it stands, so it must be shortened upstream
   always_comb begin
      cnt_d = cnt_q;
      ph_d = 4'h0;
      if (input_clock_strobe) begin
         cnt_d = cnt_q + 2'h1;
         ph_d = ftg_phase_of(cnt_q);
      end
   end

   // one-hot strobes can never overlap and last one cycle
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         cnt_q <= ftg_pkg::FTG_CNT_RST;
         ph_q <= 4'h0;
      end else begin
         cnt_q <= cnt_d;
         ph_q <= ph_d;
      end
   end

   // ------------------------------------------------------------
   // countdown chain and sync trains
   // ------------------------------------------------------------
   logic [ftg_pkg::FTG_CHAIN_STAGES-1:0] master_q, master_d;
   logic [ftg_pkg::FTG_CHAIN_STAGES-1:0] slave_q, slave_d;
   logic rate_6k4_d, rate_800_d, fast_sync_d, sync_d;

   // toggle request per stage: a stage flips once all lower stages hold ones
   function automatic logic [ftg_pkg::FTG_CHAIN_STAGES-1:0] ftg_ripple(
      input logic [ftg_pkg::FTG_CHAIN_STAGES-1:0] count
   );
      logic [ftg_pkg::FTG_CHAIN_STAGES-1:0] carry;
      carry[0] = 1'b1;
      for (int i = 1; i < ftg_pkg::FTG_CHAIN_STAGES; i++) begin
         carry[i] = carry[i-1] & count[i-1];
      end
      return carry;
   endfunction : ftg_ripple

   // masters toggle on phase four, slaves copy them on phase one; the two
   // gates never meet, so only one flop of a stage moves in any cycle
   always_comb begin
      master_d = master_q;
      slave_d = slave_q;
      rate_6k4_d = 1'b0;
      rate_800_d = 1'b0;
      if (ph_q[3]) begin
         master_d = slave_q ^ ftg_ripple(slave_q);
         rate_6k4_d = slave_q[0];
         rate_800_d = &slave_q;
      end
      if (ph_q[0]) begin
         slave_d = master_q;
      end
      fast_sync_d = coarse_align_enable ? rate_6k4_d : ph_q[3];
      sync_d = ph_q[1] | ph_q[3];
   end

   // registers
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         master_q <= ftg_pkg::FTG_CHAIN_RST;
         slave_q <= ftg_pkg::FTG_CHAIN_RST;
         rate_6k4_q <= 1'b0;
         rate_800_q <= 1'b0;
         fast_sync_q <= 1'b0;
         sync_25k6_q <= 1'b0;
      end else begin
         master_q <= master_d;
         slave_q <= slave_d;
         rate_6k4_q <= rate_6k4_d;
         rate_800_q <= rate_800_d;
         fast_sync_q <= fast_sync_d;
         sync_25k6_q <= sync_d;
      end
   end

   // ------------------------------------------------------------
   // probe generator
   // ------------------------------------------------------------
   logic hold_q, hold_d;
   logic arm_q, arm_d;
   logic p2_d, p3_d;

   // hold flop catches a probe at any time; set wins over clear
   // limitation: a probe landing after phase one of a cycle that already
   // fires the pair is swept away by the second probe and merges with it
   always_comb begin
      hold_d = hold_q;
      arm_d = arm_q;
      p2_d = ph_d[1] && arm_q;
      p3_d = ph_d[2] && arm_q;
      if (p2_d) begin
         hold_d = 1'b0;
      end
      if (probe_pulse) begin
         hold_d = 1'b1;
      end
      if (ph_d[0]) begin
         arm_d = hold_q;
      end else if (ph_d[3]) begin
         arm_d = 1'b0;
      end
   end

   // registers
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         hold_q <= 1'b0;
         arm_q <= 1'b0;
         second_probe_pulse <= 1'b0;
         third_probe_pulse <= 1'b0;
      end else begin
         hold_q <= hold_d;
         arm_q <= arm_d;
         second_probe_pulse <= p2_d;
         third_probe_pulse <= p3_d;
      end
   end

   // ------------------------------------------------------------
   // output mapping and up-down stage
   // ------------------------------------------------------------
   // strobes and divider bits come straight from their flops
   assign phase1_q = ph_q[0];
   assign phase2_q = ph_q[1];
   assign phase3_q = ph_q[2];
   assign phase4_q = ph_q[3];
   assign div_a_q = cnt_q[0];
   assign div_b_q = cnt_q[1];

   // example read-counter stage timed by the phase strobes
   ftg_updown_stage u_stage (
      .clock(clock),
      .reset_n(reset_n),
      .phase2(ph_q[1]),
      .phase4(ph_q[3]),
      .count_up(count_up),
      .count_down(count_down),
      .count_in(count_in),
      .bit_q(ud_bit),
      .carry_q(ud_carry),
      .borrow_q(ud_borrow)
   );
endmodule : ftg_timing_gen

/* rtl/ftg_updown_stage.sv */
// one up-down counter stage with carry and borrow pulses
`timescale 1ns/1ps
module ftg_updown_stage (
   // clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // phase strobes
   input wire logic phase2,
   input wire logic phase4,
   // direction levels and count request
   input wire logic count_up,
   input wire logic count_down,
   input wire logic count_in,
   // stage outputs
   output logic bit_q,
   output logic carry_q,
   output logic borrow_q
);
   logic dir_up_q, dir_up_d;
   logic bit_d, carry_d, borrow_d;

   // direction latched only at phase 2, count applied at phase 4
   always_comb begin
      dir_up_d = dir_up_q;
      bit_d = bit_q;
      carry_d = 1'b0;
      borrow_d = 1'b0;
      if (phase2 && (count_up != count_down)) begin
         dir_up_d = count_up;
      end
      if (phase4 && count_in) begin
         bit_d = ~bit_q;
         carry_d = dir_up_q && bit_q;
         borrow_d = !dir_up_q && !bit_q;
      end
   end

   // registers
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         dir_up_q <= 1'b1;
         bit_q <= 1'b0;
         carry_q <= 1'b0;
         borrow_q <= 1'b0;
      end else begin
         dir_up_q <= dir_up_d;
         bit_q <= bit_d;
         carry_q <= carry_d;
         borrow_q <= borrow_d;
      end
   end
endmodule : ftg_updown_stage

/* tb/ftg_monitor.sv */
// concurrent checks on the timing generator ports
`timescale 1ns/1ps
module ftg_monitor (
   // clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // watched inputs
   input wire logic input_clock_strobe,
   input wire logic coarse_align_enable,
   input wire logic count_in,
   // phase strobes and divider
   input wire logic phase1_q,
   input wire logic phase2_q,
   input wire logic phase3_q,
   input wire logic phase4_q,
   input wire logic div_a_q,
   input wire logic div_b_q,
   // trains and probes
   input wire logic rate_6k4_q,
   input wire logic fast_sync_q,
   input wire logic sync_25k6_q,
   input wire logic second_probe_pulse,
   input wire logic third_probe_pulse,
   // up-down stage
   input wire logic ud_bit,
   input wire logic ud_carry,
   input wire logic ud_borrow
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);
   // divider count, a is the low bit
   wire logic [1:0] cnt = {div_b_q, div_a_q};
   sequence s_i2; second_probe_pulse; endsequence
   sequence s_i3_soon; ##[1:40] third_probe_pulse; endsequence
   a_count_step: assert property (input_clock_strobe |=> cnt == $past(cnt) + 2'h1)
      else $error("divider did not step");
   a_phase_one: assert property (input_clock_strobe && cnt == 2'h0 |=> phase1_q)
      else $error("phase one missing");
   a_phase_four: assert property (input_clock_strobe && cnt == 2'h3 |=> phase4_q)
      else $error("phase four missing");
   a_phase_cause: assert property ((phase1_q | phase2_q | phase3_q | phase4_q) |-> $past(input_clock_strobe))
      else $error("phase without strobe");
   a_no_overlap: assert property ($onehot0({phase1_q, phase2_q, phase3_q, phase4_q}))
      else $error("phases coincide");
   a_rate_cause: assert property (rate_6k4_q |-> $past(phase4_q))
      else $error("halved train off phase four");
   a_fast_normal: assert property (!$past(coarse_align_enable) |-> fast_sync_q == $past(phase4_q))
      else $error("fast sync not phase four");
   a_fast_coarse: assert property ($past(coarse_align_enable) |-> fast_sync_q == rate_6k4_q)
      else $error("fast sync not halved train");
   a_sync_or: assert property (sync_25k6_q == $past(phase2_q | phase4_q))
      else $error("sync not phase two or four");
   a_probe_two: assert property (s_i2 |-> phase2_q ##0 s_i3_soon)
      else $error("probe pulses out of phase");
   a_ud_toggle: assert property (phase4_q && count_in |=> ud_bit != $past(ud_bit))
      else $error("up-down stage did not count");
   a_carry_dir: assert property (ud_carry |-> $past(ud_bit) && !ud_borrow)
      else $error("carry without set bit");
endmodule : ftg_monitor
bind ftg_timing_gen ftg_monitor u_mon (
   .clock(clock),
   .reset_n(reset_n),
   .input_clock_strobe(input_clock_strobe),
   .coarse_align_enable(coarse_align_enable),
   .count_in(count_in),
   .phase1_q(phase1_q),
   .phase2_q(phase2_q),
   .phase3_q(phase3_q),
   .phase4_q(phase4_q),
   .div_a_q(div_a_q),
   .div_b_q(div_b_q),
   .rate_6k4_q(rate_6k4_q),
   .fast_sync_q(fast_sync_q),
   .sync_25k6_q(sync_25k6_q),
   .second_probe_pulse(second_probe_pulse),
   .third_probe_pulse(third_probe_pulse),
   .ud_bit(ud_bit),
   .ud_carry(ud_carry),
   .ud_borrow(ud_borrow)
);

/* tb/ftg_src.sv */
// computer clock strobe and probe pulse source
`timescale 1ns/1ps
module ftg_src #(parameter int PER = 6) (
   // clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // pulses toward the generator
   output logic input_clock_strobe,
   output logic probe_pulse
);
   int div_q;
   int scnt_q;
   // short strobe period keeps the run brief; probe once per 32 strobes
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         div_q <= 0;
         scnt_q <= 0;
         input_clock_strobe <= 1'b0;
         probe_pulse <= 1'b0;
      end else begin
         div_q <= (div_q == PER - 1) ? 0 : div_q + 1;
         if (div_q == PER - 1) scnt_q <= (scnt_q + 1) % 32;
         input_clock_strobe <= (div_q == PER - 1);
         probe_pulse <= (div_q == 2 && scnt_q == 5);
      end
   end
endmodule : ftg_src

/* tb/ftg_timing_gen_tb.sv */
// self-checking bench for the timing generator
`timescale 1ns/1ps
module ftg_timing_gen_tb;
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic coarse_align_enable = 1'b0;
   logic count_up = 1'b1;
   logic count_down = 1'b0;
   logic count_in = 1'b0;
   logic input_clock_strobe, probe_pulse, phase1_q, phase2_q, phase3_q, phase4_q;
   logic div_a_q, div_b_q, rate_6k4_q, rate_800_q, fast_sync_q, sync_25k6_q;
   logic second_probe_pulse, third_probe_pulse, ud_bit, ud_carry, ud_borrow;
   int n_mismatch = 0;
   int num_checks = 0;
   int n_p4, n_6k, n_800, n_fs, n_sy, n_i2, n_i3, n_cy, n_bw;
   always #2 clock = ~clock;
   ftg_src u_src (
      .clock(clock),
      .reset_n(reset_n),
      .input_clock_strobe(input_clock_strobe),
      .probe_pulse(probe_pulse)
   );
   ftg_timing_gen u_dut (
      .clock(clock),
      .reset_n(reset_n),
      .input_clock_strobe(input_clock_strobe),
      .coarse_align_enable(coarse_align_enable),
      .probe_pulse(probe_pulse),
      .count_up(count_up),
      .count_down(count_down),
      .count_in(count_in),
      .phase1_q(phase1_q),
      .phase2_q(phase2_q),
      .phase3_q(phase3_q),
      .phase4_q(phase4_q),
      .div_a_q(div_a_q),
      .div_b_q(div_b_q),
      .rate_6k4_q(rate_6k4_q),
      .rate_800_q(rate_800_q),
      .fast_sync_q(fast_sync_q),
      .sync_25k6_q(sync_25k6_q),
      .second_probe_pulse(second_probe_pulse),
      .third_probe_pulse(third_probe_pulse),
      .ud_bit(ud_bit),
      .ud_carry(ud_carry),
      .ud_borrow(ud_borrow)
   );
   // event counters, cleared at the start of each window; sampled on the
   // falling edge so every registered output has settled
   always @(negedge clock) begin
      if (phase4_q) n_p4++;
      if (rate_6k4_q) n_6k++;
      if (rate_800_q) n_800++;
      if (fast_sync_q) n_fs++;
      if (sync_25k6_q) n_sy++;
      if (second_probe_pulse) n_i2++;
      if (third_probe_pulse) n_i3++;
      if (ud_carry) n_cy++;
      if (ud_borrow) n_bw++;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %0t %s: got %0h expected %0h", $time, what, got, exp);
      end
   endtask : chk
   task automatic step();
      @(posedge clock);
      #1;
   endtask : step
   // window opens just after a phase four and closes after n more of them
   task automatic win(input int n);
      while (phase4_q !== 1'b1) step();
      step();
      {n_p4, n_6k, n_800, n_fs, n_sy, n_i2, n_i3, n_cy, n_bw} = '0;
      while (n_p4 < n) step();
   endtask : win
   task automatic t_phases();
      for (int k = 0; k < 8; k++) begin
         while (input_clock_strobe !== 1'b1) step();
         step();
         chk({phase4_q, phase3_q, phase2_q, phase1_q}, 4'h1 << (k % 4), "phase order");
      end
   endtask : t_phases
   task automatic t_rates();
      count_in = 1'b1;
      win(32);
      chk(n_6k, 16, "halved train count");
      chk(n_800, 2, "slow train count");
      chk(n_fs, 32, "fast sync count");
      chk(n_sy, 64, "sync train count");
      chk(n_i2, 4, "second probe count");
      chk(n_i3, 4, "third probe count");
      chk(n_cy, 16, "carry count");
   endtask : t_rates
   task automatic t_coarse();
      coarse_align_enable = 1'b1;
      count_up = 1'b0;
      count_down = 1'b1;
      win(3);
      win(32);
      chk(n_fs, 16, "coarse fast sync count");
      chk(n_bw, 16, "borrow count");
      chk(n_cy, 0, "carry while down");
      coarse_align_enable = 1'b0;
   endtask : t_coarse
   task automatic t_reset();
      reset_n = 1'b0;
      step();
      chk({phase4_q, phase3_q, phase2_q, phase1_q, div_b_q, div_a_q}, 6'h0, "state in reset");
      reset_n = 1'b1;
      t_phases();
   endtask : t_reset
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : conclude
   initial begin
      repeat (20) @(posedge clock);
      #1 reset_n = 1'b1;
      t_phases();
      t_rates();
      t_coarse();
      t_reset();
      conclude();
   end
   // the tests need about 1800 cycles; allow over ten times that
   initial begin
      #100000;
      n_mismatch++;
      conclude();
   end
endmodule : ftg_timing_gen_tb
